/* File: logic/uie_ctrl.sv */
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
// Overview of operation
// - enable bits 4-7 writable only in extended mode, cleared otherwise.
// - after reset the enable register uses the non-extended uart layout.
// - three layouts: non-extended, extended uart/ask-ir/serial-ir, consumer-ir.
// - non-extended bit 0 enables rx high level and timeout, codes 0100/1100.
// - non-extended bit 1 enables tx low level, code 0010.
// - non-extended bit 2 enables link status, code 0110.
// - non-extended bit 3 enables modem status, code 0000.
// - extended bit 0 interrupts on rx fifo at threshold or timeout.
// - extended bit 1 interrupts on tx fifo below threshold or holding empty.
// - extended bit 4 enables terminal count interrupt only with dma enabled.
// - extended bit 5 interrupts once transmitter and tx fifo are empty.
// - consumer-ir bits 1-0 and 7-3 mean as in extended uart.
// - consumer-ir bit 2 enables link status on receive, underrun on transmit.
// - every enable bit resets to 0.
// - event identification read and fifo control write share one address.
// - non-extended pending flag reads 1 when nothing pending, default 1.
// - extended event flags set regardless of enables.
// - extended select 0 means non-extended mode.
module uie_ctrl (
  input  logic                 clk_i,
  input  logic                 rst_i,
  input  logic                 wb_cyc_i,
  input  logic                 wb_stb_i,
  input  logic                 wb_we_i,
  input  logic [7:0]           wb_adr_i,
  input  logic [3:0]           wb_sel_i,
  input  logic [31:0]          wb_dat_i,
  output logic [31:0]          wb_dat_o,
  output logic                 wb_ack_o,
  input  uie_pkg::uie_events_t ev_i,
  input  logic                 tx_active_i,
  output logic [7:0]           fifo_control_o,
  output logic                 fifo_control_wr_o,
  output logic                 extended_o,
  output logic                 irq_o
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  logic [7:0]  interrupt_enable;
  logic [7:0]  mode_ctl;
  logic [7:0]  fifo_control;
  logic        fifo_wr;
  logic        dma_flag;
  logic        irq;
  logic        ack;
  logic [31:0] rdata;
  logic [7:0]  next_ie;
  logic [7:0]  next_mode;
  logic [7:0]  next_fifo_control;
  logic        next_fifo_wr;
  logic        next_dma;
  logic        next_irq;
  logic        next_ack;
  logic [31:0] next_rdata;
  logic        ext;
  logic        next_ext;
  logic        dma_en;
  logic        cir;
  logic        req;
  logic        wr;
  logic        rd;
  logic [3:0]  prio_id;
  logic [7:0]  eid_read;
  logic [5:0]  ext_flags;
  logic [5:0]  ext_gate;

  assign ext    = mode_ctl[uie_pkg::MODE_EXT_BIT];
  assign dma_en = mode_ctl[uie_pkg::MODE_DMA_BIT];
  // consumer-ir layout only in its own group
  assign cir    = ext && (mode_ctl[uie_pkg::MODE_GRP_LO +: 2] == uie_pkg::GRP_CIR);

  assign req = wb_cyc_i && wb_stb_i && !ack;
  assign wr  = req && wb_we_i && wb_sel_i[0];
  assign rd  = req && !wb_we_i;

  uie_prio u_prio (
    .ev_i (ev_i),
    .ie_i (interrupt_enable[3:0]),
    .id_o (prio_id)
  );

  // flags follow events whatever the enables
  always_comb begin
    ext_flags = '0;
    ext_flags[uie_pkg::IE_RX_HIGH]  = ev_i.rx_high || ev_i.rx_timeout;
    ext_flags[uie_pkg::IE_TX_LOW]   = ev_i.tx_low;
    ext_flags[uie_pkg::IE_LINK]     = ev_i.link_status || (cir && ev_i.tx_underrun);
    ext_flags[uie_pkg::IE_MODEM]    = ev_i.modem_status;
    ext_flags[uie_pkg::IE_TRANSFER] = dma_flag;
    ext_flags[uie_pkg::IE_TX_EMPTY] = ev_i.tx_empty;
  end

  // gating terms for the interrupt output in extended layouts
  always_comb begin
    ext_gate = ext_flags;
    // direction picks link status or underrun
    if (cir) begin
      ext_gate[uie_pkg::IE_LINK] = tx_active_i ? ev_i.tx_underrun : ev_i.link_status;
    end
    // terminal count only while dma enabled
    ext_gate[uie_pkg::IE_TRANSFER] = dma_flag && dma_en;
  end

  always_comb begin
    if (ext) begin
      eid_read = {2'b00, ext_flags};
    end else begin
      // none-pending code carries the pending flag at 1
      eid_read = {{2{fifo_control[uie_pkg::FIFO_CTL_EN]}}, 2'b00, prio_id};
    end
  end

  always_comb begin
    next_ack   = req;
    next_rdata = '0;
    if (rd) begin
      if (hit(wb_adr_i, uie_pkg::ADR_IE)) begin
        next_rdata = {24'h000000, interrupt_enable};
      end else if (hit(wb_adr_i, uie_pkg::ADR_EID)) begin
        next_rdata = {24'h000000, eid_read};
      end else if (hit(wb_adr_i, uie_pkg::ADR_MODE)) begin
        next_rdata = {24'h000000, mode_ctl};
      end
    end
  end

  always_comb begin
    next_mode = mode_ctl;
    if (wr && hit(wb_adr_i, uie_pkg::ADR_MODE)) begin
      next_mode = wb_dat_i[7:0] & uie_pkg::MODE_MASK;
    end
    next_ext = next_mode[uie_pkg::MODE_EXT_BIT];
  end

  always_comb begin
    next_ie = interrupt_enable;
    if (wr && hit(wb_adr_i, uie_pkg::ADR_IE)) begin
      next_ie = wb_dat_i[7:0];
    end
    // upper bits forced clear outside extended mode
    if (!next_ext) begin
      next_ie = next_ie & ~uie_pkg::IE_UPPER_MASK;
    end
  end

  // writes to the shared address land in fifo control
  always_comb begin
    next_fifo_control = fifo_control;
    next_fifo_wr      = 1'b0;
    if (wr && hit(wb_adr_i, uie_pkg::ADR_EID)) begin
      next_fifo_control = wb_dat_i[7:0];
      next_fifo_wr = 1'b1;
    end
  end

  // terminal count flag: set wins over clear-on-read
  always_comb begin
    next_dma = dma_flag;
    if (rd && ext && hit(wb_adr_i, uie_pkg::ADR_EID)) begin
      next_dma = 1'b0;
    end
    if (ev_i.dma_tc && dma_en) begin
      next_dma = 1'b1;
    end
  end

  // interrupt output from enabled pending events
  always_comb begin
    if (ext) begin
      // bit 0 to bit 5 gates, shared layout
      next_irq = |(interrupt_enable[5:0] & ext_gate);
    end else begin
      next_irq = (prio_id != uie_pkg::ID_NONE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ctl         <= uie_pkg::MODE_RST;
      interrupt_enable <= uie_pkg::IE_RST;
      fifo_control     <= uie_pkg::FIFO_CTL_RST;
      fifo_wr          <= 1'b0;
      dma_flag         <= 1'b0;
      irq              <= 1'b0;
      ack              <= 1'b0;
      rdata            <= '0;
    end else begin
      mode_ctl         <= next_mode;
      interrupt_enable <= next_ie;
      fifo_control     <= next_fifo_control;
      fifo_wr          <= next_fifo_wr;
      dma_flag         <= next_dma;
      irq              <= next_irq;
      ack              <= next_ack;
      rdata            <= next_rdata;
    end
  end

  assign wb_ack_o          = ack;
  assign wb_dat_o          = rdata;
  assign fifo_control_o    = fifo_control;
  assign fifo_control_wr_o = fifo_wr;
  assign extended_o        = ext;
  assign irq_o             = irq;

  sequence s_eid_write;
    wr && hit(wb_adr_i, uie_pkg::ADR_EID);
  endsequence

  sequence s_eid_read;
    rd && hit(wb_adr_i, uie_pkg::ADR_EID) && ext;
  endsequence

  property p_upper_clear;
    @(posedge clk_i) disable iff (rst_i)
      !ext |-> ((interrupt_enable & uie_pkg::IE_UPPER_MASK) == 8'h00);
  endproperty
  a_upper_clear: assert property (p_upper_clear) else $error("upper enables set");

  property p_reset_state;
    @(posedge clk_i) $past(rst_i) && !rst_i |-> !ext && (interrupt_enable == uie_pkg::IE_RST);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");

  property p_rx_nonext;
    @(posedge clk_i) disable iff (rst_i)
      !ext && !ev_i.link_status && interrupt_enable[uie_pkg::IE_RX_HIGH] && ev_i.rx_timeout
      |-> prio_id == uie_pkg::ID_RX_TO ##1 irq_o;
  endproperty
  a_rx_nonext: assert property (p_rx_nonext) else $error("rx timeout not reported");

  property p_tx_nonext;
    @(posedge clk_i) disable iff (rst_i)
      !ext && (interrupt_enable[3:0] == 4'h2) && ev_i.tx_low
      |-> prio_id == uie_pkg::ID_TX_LOW ##1 irq_o;
  endproperty
  a_tx_nonext: assert property (p_tx_nonext) else $error("tx low not reported");

  property p_link_nonext;
    @(posedge clk_i) disable iff (rst_i)
      !ext && interrupt_enable[uie_pkg::IE_LINK] && ev_i.link_status
      |-> prio_id == uie_pkg::ID_LINK ##1 irq_o;
  endproperty
  a_link_nonext: assert property (p_link_nonext) else $error("link not reported");

  property p_modem_nonext;
    @(posedge clk_i) disable iff (rst_i)
      !ext && (interrupt_enable[3:0] == 4'h8) && ev_i.modem_status
      |-> prio_id == uie_pkg::ID_MODEM ##1 irq_o;
  endproperty
  a_modem_nonext: assert property (p_modem_nonext) else $error("modem not reported");

  property p_dma_gate;
    @(posedge clk_i) disable iff (rst_i)
      ext && !dma_en && ((interrupt_enable & ~8'h10) == 8'h00) |=> !irq_o;
  endproperty
  a_dma_gate: assert property (p_dma_gate) else $error("tc irq without dma");

  property p_empty_ext;
    @(posedge clk_i) disable iff (rst_i)
      ext && interrupt_enable[uie_pkg::IE_TX_EMPTY] && ev_i.tx_empty |=> irq_o;
  endproperty
  a_empty_ext: assert property (p_empty_ext) else $error("tx empty irq missing");

  property p_cir_dir;
    @(posedge clk_i) disable iff (rst_i)
      cir && (interrupt_enable == 8'h04) && tx_active_i && ev_i.link_status
      && !ev_i.tx_underrun |=> !irq_o;
  endproperty
  a_cir_dir: assert property (p_cir_dir) else $error("link irq during transmit");

  property p_fifo_ctl_write;
    @(posedge clk_i) disable iff (rst_i)
      s_eid_write |=> fifo_control_o == $past(wb_dat_i[7:0]) && fifo_control_wr_o;
  endproperty
  a_fifo_ctl_write: assert property (p_fifo_ctl_write) else $error("fifo control not written");

  property p_flag_read;
    @(posedge clk_i) disable iff (rst_i)
      s_eid_read |=> wb_ack_o && (wb_dat_o[uie_pkg::IE_TX_EMPTY] == $past(ev_i.tx_empty));
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag read mismatch");

  property p_no_enable;
    @(posedge clk_i) disable iff (rst_i)
      (interrupt_enable == 8'h00) |=> !irq_o;
  endproperty
  a_no_enable: assert property (p_no_enable) else $error("irq with no enables");

endmodule

/* File: logic/uie_pkg.sv */
package uie_pkg;

  // register word indices; byte address is four times the index
  localparam int unsigned IDX_IE   = 1;
  localparam int unsigned IDX_EID  = 2;
  localparam int unsigned IDX_MODE = 8;
  localparam int unsigned ADR_W    = 8;
  localparam logic [7:0] ADR_IE   = 8'(IDX_IE * 4);
  localparam logic [7:0] ADR_EID  = 8'(IDX_EID * 4);
  localparam logic [7:0] ADR_MODE = 8'(IDX_MODE * 4);

  // interrupt_enable bit positions
  localparam int unsigned IE_RX_HIGH  = 0;
  localparam int unsigned IE_TX_LOW   = 1;
  localparam int unsigned IE_LINK     = 2;
  localparam int unsigned IE_MODEM    = 3;
  localparam int unsigned IE_TRANSFER = 4;
  localparam int unsigned IE_TX_EMPTY = 5;
  localparam logic [7:0] IE_RST        = 8'h00;
  localparam logic [7:0] IE_UPPER_MASK = 8'hf0;
  localparam logic [7:0] IE_EXT_USED   = 8'h3f;

  // mode register layout
  localparam int unsigned MODE_EXT_BIT = 0;
  localparam int unsigned MODE_GRP_LO  = 1;
  localparam int unsigned MODE_DMA_BIT = 3;
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] MODE_MASK = 8'h0f;
  localparam logic [1:0] GRP_UART = 2'h0;
  localparam logic [1:0] GRP_ASK  = 2'h1;
  localparam logic [1:0] GRP_SERIAL_IR = 2'h2;
  localparam logic [1:0] GRP_CIR  = 2'h3;

  // non-extended event identification codes
  localparam logic [3:0] ID_NONE    = 4'h1;
  localparam logic [3:0] ID_LINK    = 4'h6;
  localparam logic [3:0] ID_RX_HIGH = 4'h4;
  localparam logic [3:0] ID_RX_TO   = 4'hc;
  localparam logic [3:0] ID_TX_LOW  = 4'h2;
  localparam logic [3:0] ID_MODEM   = 4'h0;

  localparam logic [7:0]  FIFO_CTL_RST = 8'h00;
  localparam int unsigned FIFO_CTL_EN  = 0;

  typedef struct packed {
    logic rx_high;
    logic rx_timeout;
    logic tx_low;
    logic link_status;
    logic modem_status;
    logic dma_tc;
    logic tx_empty;
    logic tx_underrun;
  } uie_events_t;

endpackage

/* File: logic/uie_prio.sv */
`timescale 1ns/1ps
// non-extended five-level priority encoder, enabled sources only
module uie_prio (
  input  uie_pkg::uie_events_t ev_i,
  input  logic [3:0]           ie_i,
  output logic [3:0]           id_o
);
  always_comb begin
    if (ie_i[uie_pkg::IE_LINK] && ev_i.link_status) begin
      id_o = uie_pkg::ID_LINK;
    end else if (ie_i[uie_pkg::IE_RX_HIGH] && ev_i.rx_timeout) begin
      id_o = uie_pkg::ID_RX_TO;
    end else if (ie_i[uie_pkg::IE_RX_HIGH] && ev_i.rx_high) begin
      id_o = uie_pkg::ID_RX_HIGH;
    end else if (ie_i[uie_pkg::IE_TX_LOW] && ev_i.tx_low) begin
      id_o = uie_pkg::ID_TX_LOW;
    end else if (ie_i[uie_pkg::IE_MODEM] && ev_i.modem_status) begin
      id_o = uie_pkg::ID_MODEM;
    end else begin
      id_o = uie_pkg::ID_NONE;
    end
  end
endmodule

/* File: verif/uie_evsrc.sv */
`timescale 1ns/1ps
// far-side event sources: levels registered, terminal count one pulse
module uie_evsrc (
  input  logic                 clk_i,
  input  logic                 rst_i,
  input  logic [7:0]           lvl_i,
  input  logic                 tc_i,
  input  logic                 tx_i,
  output uie_pkg::uie_events_t ev_o,
  output logic                 tx_active_o
);
  logic [7:0] lvl;
  logic       tc;
  always_ff @(posedge clk_i) begin
    lvl <= rst_i ? 8'h00 : lvl_i;
    tc <= !rst_i && tc_i && !tc;
    tx_active_o <= !rst_i && tx_i;
  end
  assign ev_o = uie_pkg::uie_events_t'({lvl[7:3], tc, lvl[1:0]});
endmodule

/* File: verif/test_uie_ctrl.sv */
`timescale 1ns/1ps
module test_uie_ctrl;
  logic                 clk_i, rst_i, cyc, stb, we, ack, fc_wr, ext, irq, fw;
  logic                 tx_req, tx_act, tc_req;
  logic [7:0]           adr, fc, lvl;
  logic [3:0]           sel;
  logic [31:0]          dat, dat_o, q;
  uie_pkg::uie_events_t ev;
  int                   err_count, samples_checked;

  uie_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .ev_i(ev), .tx_active_i(tx_act), .fifo_control_o(fc),
    .fifo_control_wr_o(fc_wr), .extended_o(ext), .irq_o(irq));
  uie_evsrc src (.clk_i(clk_i), .rst_i(rst_i), .lvl_i(lvl), .tc_i(tc_req),
    .tx_i(tx_req), .ev_o(ev), .tx_active_o(tx_act));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) err_count++;
    q = dat_o;
    fw = fc_wr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, {24'h000000, e});
  endtask

  task automatic st();
    repeat (4) @(posedge clk_i);
  endtask

  task automatic t_reset();
    rdc(uie_pkg::ADR_IE, 8'h00);
    rdc(uie_pkg::ADR_EID, 8'h01);
    rdc(uie_pkg::ADR_MODE, 8'h00);
    chk(ext, 1'b0);
    chk(irq, 1'b0);
    wb(1'b1, uie_pkg::ADR_EID, 8'h01);
    chk(fw, 1'b1);
    chk(fc, 8'h01);
    rdc(uie_pkg::ADR_EID, 8'hc1);
    chk(fw, 1'b0);
    wb(1'b1, uie_pkg::ADR_EID, 8'h00);
    // lane 0 not selected: write ignored
    sel <= 4'h0;
    wb(1'b1, uie_pkg::ADR_IE, 8'h0f);
    sel <= 4'h1;
    rdc(uie_pkg::ADR_IE, 8'h00);
  endtask

  task automatic t_nonext();
    logic [7:0] ev_t[5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08};
    logic [7:0] ie_t[5] = '{8'h01, 8'h01, 8'h02, 8'h04, 8'h08};
    logic [7:0] id_t[5] = '{8'h04, 8'h0c, 8'h02, 8'h06, 8'h00};
    wb(1'b1, uie_pkg::ADR_IE, 8'hff);
    rdc(uie_pkg::ADR_IE, 8'h0f);
    for (int i = 0; i < 5; i++) begin
      lvl <= ev_t[i];
      wb(1'b1, uie_pkg::ADR_IE, ie_t[i]);
      st();
      rdc(uie_pkg::ADR_EID, id_t[i]);
      chk(irq, 1'b1);
      wb(1'b1, uie_pkg::ADR_IE, ~ie_t[i] & 8'h0f);
      st();
      rdc(uie_pkg::ADR_EID, 8'h01);
      chk(irq, 1'b0);
    end
    lvl <= 8'hf8;
    wb(1'b1, uie_pkg::ADR_IE, 8'h0f);
    rdc(uie_pkg::ADR_EID, 8'h06);
    wb(1'b1, uie_pkg::ADR_IE, 8'h00);
    lvl <= 8'h00;
    st();
  endtask

  task automatic t_ext();
    logic [7:0] ev_t[6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02};
    logic [7:0] bt_t[6] = '{8'h01, 8'h01, 8'h02, 8'h04, 8'h08, 8'h20};
    wb(1'b1, uie_pkg::ADR_MODE, 8'h01);
    chk(ext, 1'b1);
    wb(1'b1, uie_pkg::ADR_IE, 8'hf0);
    wb(1'b1, uie_pkg::ADR_MODE, 8'h04);
    rdc(uie_pkg::ADR_IE, 8'h00);
    rdc(uie_pkg::ADR_MODE, 8'h04);
    chk(ext, 1'b0);
    wb(1'b1, uie_pkg::ADR_MODE, 8'h01);
    for (int i = 0; i < 6; i++) begin
      lvl <= ev_t[i];
      st();
      rdc(uie_pkg::ADR_EID, bt_t[i]);
      chk(irq, 1'b0);
      wb(1'b1, uie_pkg::ADR_IE, bt_t[i]);
      st();
      chk(irq, 1'b1);
      wb(1'b1, uie_pkg::ADR_IE, ~bt_t[i] & 8'h3f);
      st();
      chk(irq, 1'b0);
      wb(1'b1, uie_pkg::ADR_IE, 8'h00);
    end
    lvl <= 8'h00;
  endtask

  task automatic t_dma(input logic [7:0] mode, input logic exp);
    wb(1'b1, uie_pkg::ADR_MODE, mode);
    wb(1'b1, uie_pkg::ADR_IE, 8'h10);
    tc_req <= 1'b1;
    @(posedge clk_i);
    tc_req <= 1'b0;
    st();
    chk(irq, exp);
    rdc(uie_pkg::ADR_EID, {3'h0, exp, 4'h0});
    rdc(uie_pkg::ADR_EID, 8'h00);
    st();
    chk(irq, 1'b0);
  endtask

  task automatic t_cir();
    // extended serial-ir: underrun is no link event
    wb(1'b1, uie_pkg::ADR_MODE, 8'h05);
    wb(1'b1, uie_pkg::ADR_IE, 8'h04);
    tx_req <= 1'b1;
    lvl <= 8'h01;
    st();
    rdc(uie_pkg::ADR_EID, 8'h00);
    chk(irq, 1'b0);
    wb(1'b1, uie_pkg::ADR_MODE, 8'h03);
    lvl <= 8'h10;
    st();
    chk(irq, 1'b1);
    wb(1'b1, uie_pkg::ADR_MODE, 8'h07);
    wb(1'b1, uie_pkg::ADR_IE, 8'h04);
    lvl <= 8'h01;
    st();
    chk(irq, 1'b1);
    rdc(uie_pkg::ADR_EID, 8'h04);
    tx_req <= 1'b0;
    st();
    chk(irq, 1'b0);
    lvl <= 8'h10;
    st();
    chk(irq, 1'b1);
    wb(1'b1, uie_pkg::ADR_IE, 8'h21);
    lvl <= 8'h82;
    st();
    rdc(uie_pkg::ADR_EID, 8'h21);
    chk(irq, 1'b1);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    tally_and_finish();
  end

  initial begin
    {rst_i, cyc, stb, we, tx_req, tc_req} = 6'h20;
    {adr, lvl, dat} = '0;
    sel = 4'h1;
    err_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_nonext();
    t_ext();
    t_dma(8'h01, 1'b0);
    t_dma(8'h09, 1'b1);
    t_cir();
    tally_and_finish();
  end
endmodule
